//--- bench/spc_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Word memory standing in for the sprite fetch engine
// ----------------------------------------------------------------------
module spc_fetch_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [1:0] delay_in,
   input wire spc_pkg::spc_fetch_req_s req_in,
   output spc_pkg::spc_fetch_rsp_s rsp_out
);
   logic [15:0] mem [0:63];
   logic [1:0] wait_cnt;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rsp_out <= '0;
         wait_cnt <= 2'h0;
      end else if (req_in.req && !rsp_out.ack && wait_cnt == delay_in) begin
         rsp_out.ack <= 1'b1;
         rsp_out.data <= mem[req_in.addr[6:1]];
         wait_cnt <= 2'h0;
      end else begin
         rsp_out.ack <= 1'b0;
         // Data toggles off the ack so stale words never look valid
         rsp_out.data <= ~rsp_out.data;
         if (req_in.req && !rsp_out.ack) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/sprite_channel_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sprite_channel_decode_tb;
   typedef struct packed {
      spc_pkg::spc_pix_s pix;
      logic [8:0] h;
      logic [8:0] v;
   } spc_exp_s;
   logic clk;
   logic rst;
   logic running;
   logic [1:0] delay;
   logic [31:0] seed;
   logic [31:0] rd;
   logic err;
   int err_total;
   int comparisons;
   int nxt;
   spc_exp_s exp_q[$];
   spc_pkg::spc_apb_req_s apb_req;
   spc_pkg::spc_apb_rsp_s apb_rsp;
   spc_pkg::spc_beam_s beam;
   spc_pkg::spc_fetch_req_s fetch_req;
   spc_pkg::spc_fetch_rsp_s fetch_rsp;
   spc_pkg::spc_pix_s pix;

   spc_sprite_channel i_spc_sprite_channel (
      .MCLK_IN(clk),
      .RST_IN(rst),
      .APB_IN(apb_req),
      .APB_OUT(apb_rsp),
      .BEAM_IN(beam),
      .FETCH_OUT(fetch_req),
      .FETCH_IN(fetch_rsp),
      .PIX_OUT(pix)
   );
   spc_fetch_model i_spc_fetch_model (
      .clk_in(clk),
      .rst_in(rst),
      .delay_in(delay),
      .req_in(fetch_req),
      .rsp_out(fetch_rsp)
   );

   always #5 clk = ~clk;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic fail(input string m);
      err_total++;
      $display("Error %0t: %s", $time, m);
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: wd};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) fail("no pready");
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wait_beam(input logic [8:0] v, input logic [8:0] h);
      int n;
      n = 0;
      while (!(beam.v == v && beam.h == h) && n < 20000) begin
         @(posedge clk);
         n++;
      end
   endtask

   // Lines from hold on keep the last fetched data on screen
   task automatic add_sprite(input int at, input logic [8:0] v0,
                             input logic [8:0] v1, input logic [8:0] hs,
                             input logic [2:0] chan, input int hold);
      logic [15:0] lo;
      logic [15:0] hi;
      logic [1:0] code;
      spc_exp_s e;
      i_spc_fetch_model.mem[at] = {v0[7:0], hs[8:1]};
      i_spc_fetch_model.mem[at+1] = {v1[7:0], 5'h00, v0[8], v1[8], hs[0]};
      for (int ln = 0; ln < int'(v1 - v0); ln++) begin
         seed = xs(seed);
         i_spc_fetch_model.mem[at+2+2*ln] = seed[15:0];
         i_spc_fetch_model.mem[at+3+2*ln] = seed[31:16];
         if (ln < hold) begin
            lo = seed[15:0];
            hi = seed[31:16];
         end
         for (int i = 0; i < 16; i++) begin
            code = {hi[15-i], lo[15-i]};
            e.pix.valid = 1'b1;
            e.pix.opaque = (code != 2'b00);
            e.pix.index = 5'h10 + {chan[2:1], 2'b00} + code;
            e.pix.prio = chan;
            e.h = hs + 9'h002 + 9'(i);
            e.v = v0 + 9'(ln);
            exp_q.push_back(e);
         end
      end
      nxt = at + 2 + 2 * int'(v1 - v0);
   endtask

   // ------------------------------------------------------------------
   // Beam counters: 64 pixels a line, 264 lines a field
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      if (running) begin
         if (beam.h == 9'h03F) begin
            beam.h <= 9'h000;
            beam.v <= (beam.v == 9'h107) ? 9'h000 : beam.v + 9'h001;
         end else begin
            beam.h <= beam.h + 9'h001;
         end
      end
   end

   // ------------------------------------------------------------------
   // Pixel monitor
   // ------------------------------------------------------------------
   always @(negedge clk) begin
      spc_exp_s e;
      if (!rst && pix.valid === 1'b1) begin
         comparisons++;
         if (exp_q.size() == 0) begin
            fail("unexpected pixel");
         end else begin
            e = exp_q.pop_front();
            if (beam.h !== e.h || beam.v !== e.v) fail("pixel place");
            if (e.pix.opaque ? (pix !== e.pix) :
                ({pix.opaque, pix.prio} !== {1'b0, e.pix.prio}))
               fail("pixel value");
         end
      end
   end

   // One field, 21 more lines and set-up need about 18300 cycles
   initial begin
      repeat (60000) @(posedge clk);
      fail("timeout");
      complete_run();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      running = 1'b0;
      delay = 2'h0;
      seed = 32'h0000_5517;
      err_total = 0;
      comparisons = 0;
      apb_req = '0;
      beam = '{h: 9'h000, v: 9'h107};
      for (int i = 0; i < 64; i++) begin
         i_spc_fetch_model.mem[i] = 16'h0000;
      end
      add_sprite(0, 9'h002, 9'h004, 9'h01F, 3'h5, 99);
      add_sprite(nxt, 9'h006, 9'h007, 9'h028, 3'h5, 99);
      add_sprite(nxt, 9'h106, 9'h107, 9'h014, 3'h5, 99);
      add_sprite(32, 9'h00A, 9'h00D, 9'h02C, 3'h2, 2);
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h1C, 32'h0000_0000);
      comparisons++;
      if (err !== 1'b1 || rd !== 32'h0000_0000) fail("unmapped read");
      apb(1'b0, spc_pkg::OFS_START_POS, 32'h0000_0000);
      comparisons++;
      if (rd !== 32'h0000_0000) fail("write-only read");
      apb(1'b1, spc_pkg::OFS_PTR_HIGH, 32'h0000_0000);
      apb(1'b1, spc_pkg::OFS_PTR_LOW, 32'h0000_0001);
      apb(1'b1, spc_pkg::OFS_CONTROL, 32'h0000_000B);
      running <= 1'b1;
      wait_beam(9'h106, 9'h000);
      wait_beam(9'h107, 9'h020);
      // Second field: slow memory, other channel pair, fetch cut mid-way
      delay <= 2'h3;
      apb(1'b1, spc_pkg::OFS_PTR_LOW, 32'h0000_0040);
      apb(1'b1, spc_pkg::OFS_CONTROL, 32'h0000_0005);
      wait_beam(9'h00B, 9'h032);
      apb(1'b1, spc_pkg::OFS_CONTROL, 32'h0000_0004);
      wait_beam(9'h014, 9'h000);
      comparisons++;
      if (exp_q.size() != 0) fail("pixels missing");
      complete_run();
   end
endmodule
`default_nettype wire

//--- core/spc_ctl_decode.sv
`timescale 1ns/10ps
`default_nettype none
module spc_ctl_decode (
   input wire logic [15:0] pos_in,
   input wire logic [15:0] ctl_in,
   output spc_pkg::spc_ctl_s ctl_out
);
   // -------------------------------------------------------------------
   // Field split
   // -------------------------------------------------------------------
   always_comb begin
      ctl_out.vertical_start_line = {ctl_in[spc_pkg::CTL_VERTICAL_START_LINE_HI_BIT],
         pos_in[spc_pkg::POS_VERTICAL_START_LINE_LSB +: 8]};
      ctl_out.horizontal_start_pixel = {pos_in[spc_pkg::POS_HORIZONTAL_START_PIXEL_LSB +: 8],
         ctl_in[spc_pkg::CTL_HORIZONTAL_START_PIXEL_LO_BIT]};
      ctl_out.vertical_stop_line = {ctl_in[spc_pkg::CTL_VERTICAL_STOP_LINE_HI_BIT],
         ctl_in[spc_pkg::CTL_VERTICAL_STOP_LINE_LSB +: 8]};
      ctl_out.attach = ctl_in[spc_pkg::CTL_ATTACH_BIT];
   end
endmodule
`default_nettype wire

//--- core/spc_pixel_shift.sv
`timescale 1ns/10ps
`default_nettype none
module spc_pixel_shift (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic load_in,
   input wire logic [15:0] lo_in,
   input wire logic [15:0] hi_in,
   output logic [1:0] code_out,
   output logic active_out
);
   spc_pkg::spc_shift_s r;
   spc_pkg::spc_shift_s next_r;

   // -------------------------------------------------------------------
   // Shifter, one low-res pixel per clock
   // -------------------------------------------------------------------
   always_comb begin
      next_r = r;
      if (load_in) begin
         next_r.lo = lo_in;
         next_r.hi = hi_in;
         next_r.count = spc_pkg::PIX_PER_LINE;
      end else if (r.count != '0) begin
         next_r.lo = {r.lo[14:0], 1'h0};
         next_r.hi = {r.hi[14:0], 1'h0};
         next_r.count = r.count - 5'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r <= spc_pkg::SHIFT_RST;
      end else begin
         r <= next_r;
      end
   end

   assign active_out = (r.count != '0);
   assign code_out = active_out ? {r.hi[15], r.lo[15]} : 2'h0;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   property p_width;
      @(posedge clk_in) disable iff (rst_in)
      load_in |=> active_out[*8] ##1 active_out[*8] ##1 !active_out;
   endproperty
   a_width: assert property (p_width)
      else $error("Sprite line is not 16 pixels wide");

   property p_first_pixel;
      @(posedge clk_in) disable iff (rst_in)
      load_in |=> code_out == {$past(hi_in[15]), $past(lo_in[15])};
   endproperty
   a_first_pixel: assert property (p_first_pixel)
      else $error("First pixel is not bit 15 of both words");

   property p_shift_order;
      @(posedge clk_in) disable iff (rst_in)
      (r.count > 5'h01 && !load_in) |=>
         code_out == {$past(r.hi[14]), $past(r.lo[14])};
   endproperty
   a_shift_order: assert property (p_shift_order)
      else $error("Pixels do not shift left one per clock");
endmodule
`default_nettype wire

//--- core/spc_sprite_channel.sv
`timescale 1ns/10ps
`default_nettype none
module spc_sprite_channel (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire spc_pkg::spc_apb_req_s APB_IN,
   output spc_pkg::spc_apb_rsp_s APB_OUT,
   input wire spc_pkg::spc_beam_s BEAM_IN,
   output spc_pkg::spc_fetch_req_s FETCH_OUT,
   input wire spc_pkg::spc_fetch_rsp_s FETCH_IN,
   output spc_pkg::spc_pix_s PIX_OUT
);
   spc_pkg::spc_main_s r;
   spc_pkg::spc_main_s next_r;
   spc_pkg::spc_ctl_s ctl;
   logic fetch_req;
   logic fetch_ack;
   logic apb_setup;
   logic apb_write;
   logic field_start;
   logic in_range;
   logic shift_load;
   logic [1:0] shift_code;
   logic shift_active;
   logic [17:0] ptr_next;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == spc_pkg::OFS_START_POS) ||
         (a == spc_pkg::OFS_STOP_CTL) || (a == spc_pkg::OFS_PTR_HIGH) ||
         (a == spc_pkg::OFS_PTR_LOW) || (a == spc_pkg::OFS_CONTROL) ||
         (a == spc_pkg::OFS_STATUS);
   endfunction

   // Pairs of channels share one group of four colour registers
   function automatic logic [4:0] color_index(input logic [2:0] ch,
      input logic [1:0] code);
      color_index = spc_pkg::COLOR_BASE + {1'h0, ch[2:1], 2'h0} +
         {3'h0, code};
   endfunction

   // -------------------------------------------------------------------
   // Control word decode and pixel shifter
   // -------------------------------------------------------------------
   spc_ctl_decode u_decode (
      .pos_in(r.pos_word),
      .ctl_in(r.ctl_word),
      .ctl_out(ctl)
   );

   spc_pixel_shift u_shift (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .load_in(shift_load),
      .lo_in(r.data_lo),
      .hi_in(r.data_hi),
      .code_out(shift_code),
      .active_out(shift_active)
   );

   // -------------------------------------------------------------------
   // Beam compare
   // -------------------------------------------------------------------
   // Beam counters count low-res, non-interlaced pixels whatever the
   // playfield mode is, so sprite size never follows the playfield.
   assign field_start = (BEAM_IN.v == spc_pkg::FIELD_START_V) &&
      (BEAM_IN.h == spc_pkg::FETCH_H);
   assign in_range = (ctl.vertical_start_line <= BEAM_IN.v) &&
      (BEAM_IN.v < ctl.vertical_stop_line);
   assign shift_load = in_range && (BEAM_IN.h == ctl.horizontal_start_pixel);

   // -------------------------------------------------------------------
   // Fetch port
   // -------------------------------------------------------------------
   assign fetch_req = (r.st == spc_pkg::S_CTL1) ||
      (r.st == spc_pkg::S_CTL2) || (r.st == spc_pkg::S_LO) ||
      (r.st == spc_pkg::S_HI);
   assign fetch_ack = fetch_req && FETCH_IN.ack;
   // Word address: lowest bit of the low pointer is dropped
   assign ptr_next = {r.ptr_high, r.ptr_low[15:1]} + 18'h0_0001;

   always_comb begin
      FETCH_OUT.req = fetch_req;
      FETCH_OUT.addr = {r.ptr_high, r.ptr_low[15:1], 1'h0};
   end

   // -------------------------------------------------------------------
   // APB slave, zero wait states
   // -------------------------------------------------------------------
   assign apb_setup = APB_IN.psel && !APB_IN.penable;
   assign apb_write = APB_IN.psel && APB_IN.penable && APB_IN.pwrite &&
      is_mapped(APB_IN.paddr);

   always_comb begin
      APB_OUT.prdata = r.prdata;
      APB_OUT.pready = 1'h1;
      APB_OUT.pslverr = APB_IN.psel && APB_IN.penable &&
         !is_mapped(APB_IN.paddr);
      PIX_OUT = r.pix;
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      next_r = r;
      if (apb_setup && !APB_IN.pwrite) begin
         next_r.prdata = '0;
         case (APB_IN.paddr)
            spc_pkg::OFS_PTR_HIGH: next_r.prdata[2:0] = r.ptr_high;
            spc_pkg::OFS_PTR_LOW: next_r.prdata[15:0] = r.ptr_low;
            spc_pkg::OFS_CONTROL: begin
               next_r.prdata[spc_pkg::CONTROL_DMA_EN_BIT] = r.dma_en;
               next_r.prdata[spc_pkg::CONTROL_CHAN_LSB +: 3] = r.chan;
            end
            spc_pkg::OFS_STATUS: begin
               next_r.prdata[2:0] = r.st;
               next_r.prdata[3] = r.field_done;
               next_r.prdata[4] = in_range;
               next_r.prdata[5] = shift_active;
               next_r.prdata[6] = ctl.attach;
            end
            default: next_r.prdata = '0;
         endcase
      end
      if (apb_write) begin
         case (APB_IN.paddr)
            spc_pkg::OFS_START_POS: next_r.pos_word = APB_IN.pwdata[15:0];
            spc_pkg::OFS_STOP_CTL: next_r.ctl_word = APB_IN.pwdata[15:0];
            spc_pkg::OFS_PTR_HIGH: next_r.ptr_high = APB_IN.pwdata[2:0];
            spc_pkg::OFS_PTR_LOW: next_r.ptr_low = APB_IN.pwdata[15:0];
            spc_pkg::OFS_CONTROL: begin
               next_r.dma_en = APB_IN.pwdata[spc_pkg::CONTROL_DMA_EN_BIT];
               next_r.chan = APB_IN.pwdata[spc_pkg::CONTROL_CHAN_LSB +: 3];
            end
            default: next_r.field_done = r.field_done;
         endcase
      end
      // Fetched words land after software writes, so hardware wins
      if (fetch_ack) begin
         next_r.ptr_high = ptr_next[17:15];
         next_r.ptr_low = {ptr_next[14:0], 1'h0};
      end
      unique case (r.st)
         spc_pkg::S_IDLE: next_r.st = r.st;
         spc_pkg::S_CTL1: begin
            if (fetch_ack) begin
               next_r.pos_word = FETCH_IN.data;
               next_r.st = spc_pkg::S_CTL2;
            end
         end
         spc_pkg::S_CTL2: begin
            if (fetch_ack) begin
               next_r.ctl_word = FETCH_IN.data;
               next_r.st = spc_pkg::S_CHECK;
            end
         end
         spc_pkg::S_CHECK: begin
            if (ctl.vertical_start_line < BEAM_IN.v) begin
               next_r.st = spc_pkg::S_DONE;
               next_r.field_done = 1'h1;
            end else begin
               next_r.st = spc_pkg::S_WAIT;
            end
         end
         spc_pkg::S_WAIT: begin
            // Without fetching the data words stay and repeat
            if (BEAM_IN.h == spc_pkg::FETCH_H && r.dma_en) begin
               if (BEAM_IN.v == ctl.vertical_stop_line) begin
                  next_r.st = spc_pkg::S_CTL1;
               end else if (in_range) begin
                  next_r.st = spc_pkg::S_LO;
               end
            end
         end
         spc_pkg::S_LO: begin
            if (fetch_ack) begin
               next_r.data_lo = FETCH_IN.data;
               next_r.st = spc_pkg::S_HI;
            end
         end
         spc_pkg::S_HI: begin
            if (fetch_ack) begin
               next_r.data_hi = FETCH_IN.data;
               next_r.st = spc_pkg::S_WAIT;
            end
         end
         spc_pkg::S_DONE: next_r.st = r.st;
      endcase
      if (field_start) begin
         next_r.field_done = 1'h0;
         next_r.st = r.dma_en ? spc_pkg::S_CTL1 : spc_pkg::S_IDLE;
      end
      // Pixel stage: one register after the shifter
      next_r.pix.valid = shift_active;
      next_r.pix.opaque = shift_active && (shift_code != 2'h0);
      next_r.pix.index = color_index(r.chan, shift_code);
      next_r.pix.prio = r.chan;
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         r <= spc_pkg::MAIN_RST;
      end else begin
         r <= next_r;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   property p_ctl_order;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (r.st == spc_pkg::S_CTL1 && fetch_ack && !field_start) |=>
         r.st == spc_pkg::S_CTL2 ##1 r.st == spc_pkg::S_CTL2 ||
         r.st == spc_pkg::S_CHECK || field_start;
   endproperty
   a_ctl_order: assert property (p_ctl_order)
      else $error("Control words not fetched in order");

   property p_ptr_step;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (fetch_ack && !apb_write) |=>
         FETCH_OUT.addr == $past(FETCH_OUT.addr) + spc_pkg::PTR_STEP;
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("Pointer did not advance one word");

   property p_stale_start;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (r.st == spc_pkg::S_CHECK && ctl.vertical_start_line < BEAM_IN.v &&
         !field_start) |=> r.st == spc_pkg::S_DONE && r.field_done;
   endproperty
   a_stale_start: assert property (p_stale_start)
      else $error("Channel not idle after passed start line");

   property p_start_pixel;
      @(posedge MCLK_IN) disable iff (RST_IN)
      shift_load |-> ##2 PIX_OUT.valid;
   endproperty
   a_start_pixel: assert property (p_start_pixel)
      else $error("No pixel output two cycles after start match");

   property p_transparent;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (shift_code == 2'h0) |=> !PIX_OUT.opaque;
   endproperty
   a_transparent: assert property (p_transparent)
      else $error("Code 00 was not transparent");

   property p_group_index;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (shift_active && shift_code != 2'h0) |=> PIX_OUT.opaque &&
         PIX_OUT.index == {1'h1, $past(r.chan[2:1]), $past(shift_code)};
   endproperty
   a_group_index: assert property (p_group_index)
      else $error("Wrong colour register for pixel code");

   property p_hold_line;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (!r.dma_en && r.st == spc_pkg::S_WAIT) |=>
         $stable(r.data_lo) && $stable(r.data_hi);
   endproperty
   a_hold_line: assert property (p_hold_line)
      else $error("Line data changed with fetching off");

   property p_no_fetch_idle;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (r.st == spc_pkg::S_DONE && !field_start) |=> !FETCH_OUT.req;
   endproperty
   a_no_fetch_idle: assert property (p_no_fetch_idle)
      else $error("Fetch requested after channel retired");

   property p_top_line;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (BEAM_IN.v == ctl.vertical_start_line && ctl.vertical_start_line < ctl.vertical_stop_line &&
         BEAM_IN.h == ctl.horizontal_start_pixel) |-> shift_load;
   endproperty
   a_top_line: assert property (p_top_line)
      else $error("Sprite top line did not start a pixel line");

   property p_line_range;
      @(posedge MCLK_IN) disable iff (RST_IN)
      shift_load |-> (ctl.vertical_start_line <= BEAM_IN.v && BEAM_IN.v < ctl.vertical_stop_line);
   endproperty
   a_line_range: assert property (p_line_range)
      else $error("Pixel line started outside start and stop");

   property p_idle_clear;
      @(posedge MCLK_IN) disable iff (RST_IN)
      !PIX_OUT.valid |-> !PIX_OUT.opaque;
   endproperty
   a_idle_clear: assert property (p_idle_clear)
      else $error("Opaque pixel outside a sprite line");

   property p_sprite_bank;
      @(posedge MCLK_IN) disable iff (RST_IN)
      PIX_OUT.opaque |-> PIX_OUT.index[4] && PIX_OUT.index[1:0] != 2'h0;
   endproperty
   a_sprite_bank: assert property (p_sprite_bank)
      else $error("Opaque pixel outside the sprite colour bank");

   property p_fixed_prio;
      @(posedge MCLK_IN) disable iff (RST_IN)
      PIX_OUT.valid |-> PIX_OUT.prio == $past(r.chan);
   endproperty
   a_fixed_prio: assert property (p_fixed_prio)
      else $error("Pixel priority is not the channel number");

   property p_lo_then_hi;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (r.st == spc_pkg::S_LO && fetch_ack && !field_start) |=>
         r.st == spc_pkg::S_HI;
   endproperty
   a_lo_then_hi: assert property (p_lo_then_hi)
      else $error("High word not fetched after low word");

   property p_stop_reload;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (r.st == spc_pkg::S_WAIT && r.dma_en && !field_start &&
         BEAM_IN.h == spc_pkg::FETCH_H && BEAM_IN.v == ctl.vertical_stop_line) |=>
         r.st == spc_pkg::S_CTL1;
   endproperty
   a_stop_reload: assert property (p_stop_reload)
      else $error("Stop line did not reload control words");

   property p_word_addr;
      @(posedge MCLK_IN) disable iff (RST_IN)
      FETCH_OUT.req |-> !FETCH_OUT.addr[0];
   endproperty
   a_word_addr: assert property (p_word_addr)
      else $error("Fetch address is not word aligned");

   property p_fetch_off_wait;
      @(posedge MCLK_IN) disable iff (RST_IN)
      (!r.dma_en && r.st == spc_pkg::S_WAIT && !field_start) |=>
         r.st == spc_pkg::S_WAIT;
   endproperty
   a_fetch_off_wait: assert property (p_fetch_off_wait)
      else $error("Channel left line wait with fetching off");
endmodule
`default_nettype wire

//--- pkg/spc_pkg.sv
`default_nettype none
package spc_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0] OFS_START_POS = 8'h00;
   localparam logic [7:0] OFS_STOP_CTL = 8'h04;
   localparam logic [7:0] OFS_PTR_HIGH = 8'h08;
   localparam logic [7:0] OFS_PTR_LOW = 8'h0C;
   localparam logic [7:0] OFS_CONTROL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam int CONTROL_DMA_EN_BIT = 0;
   localparam int CONTROL_CHAN_LSB = 1;
   // -------------------------------------------------------------------
   // Control word fields
   // -------------------------------------------------------------------
   localparam int POS_VERTICAL_START_LINE_LSB = 8;
   localparam int POS_HORIZONTAL_START_PIXEL_LSB = 0;
   localparam int CTL_VERTICAL_STOP_LINE_LSB = 8;
   localparam int CTL_ATTACH_BIT = 7;
   localparam int CTL_VERTICAL_START_LINE_HI_BIT = 2;
   localparam int CTL_VERTICAL_STOP_LINE_HI_BIT = 1;
   localparam int CTL_HORIZONTAL_START_PIXEL_LO_BIT = 0;
   localparam logic [8:0] VERTICAL_START_LINE_MAX = 9'h106;
   // -------------------------------------------------------------------
   // Timing and colour constants
   // -------------------------------------------------------------------
   localparam logic [4:0] PIX_PER_LINE = 5'h10;
   localparam logic [8:0] FETCH_H = 9'h000;
   localparam logic [8:0] FIELD_START_V = 9'h000;
   localparam logic [4:0] COLOR_BASE = 5'h10;
   localparam logic [18:0] PTR_STEP = 19'h0_0002;
   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_CTL1, S_CTL2, S_CHECK, S_WAIT, S_LO, S_HI, S_DONE
   } spc_state_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } spc_apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } spc_apb_rsp_s;
   typedef struct packed {
      logic [8:0] h;
      logic [8:0] v;
   } spc_beam_s;
   typedef struct packed {
      logic req;
      logic [18:0] addr;
   } spc_fetch_req_s;
   typedef struct packed {
      logic ack;
      logic [15:0] data;
   } spc_fetch_rsp_s;
   typedef struct packed {
      logic valid;
      logic opaque;
      logic [4:0] index;
      logic [2:0] prio;
   } spc_pix_s;
   typedef struct packed {
      logic [8:0] vertical_start_line;
      logic [8:0] vertical_stop_line;
      logic [8:0] horizontal_start_pixel;
      logic attach;
   } spc_ctl_s;
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] hi;
      logic [4:0] count;
   } spc_shift_s;
   typedef struct packed {
      spc_state_e st;
      logic [15:0] pos_word;
      logic [15:0] ctl_word;
      logic [2:0] ptr_high;
      logic [15:0] ptr_low;
      logic [15:0] data_lo;
      logic [15:0] data_hi;
      logic dma_en;
      logic [2:0] chan;
      logic field_done;
      logic [31:0] prdata;
      spc_pix_s pix;
   } spc_main_s;
   localparam spc_shift_s SHIFT_RST = '0;
   localparam spc_main_s MAIN_RST = '0;
endpackage
`default_nettype wire
